// ### shared/ept_pkg.sv
// Overview of operation
// - Run bit 7 set raises the thread's execution request; clear drops it.
// - Writing 1 to control bit 6 clears state and prescaler; write-only.
// - Priority group bits 1:0: 00 ungrouped, 01 A, 10 B, 11 C.
// - Status bits 7:6: 00 stopped, 01 active, 10 event wait, 11 timer wait.
// - Writing 1 to status bit 5 sets flag A; reads as 0.
// - Writing 1 to status bit 4 sets flag B; reads as 0.
// - Flags at status bits 1,0 read their value; writing 1 clears.
// - Host clear beats force set; force set beats core update.
// - Low-byte write is buffered, committed with the high-byte write.
// - Low-byte read latches the high byte; high-byte read returns the latch.
// - Host write to gp, counter or timer beats a core update.
// - Program counter high byte holds only counter bit 8 at bit 0.
// - Reserved bits read 0; host writes 0 to them.
// - The register set is replicated for six threads, 0 through 5.
// - General registers 16 bits, program counter 9 bits, timer 12 bits.
// - Host and core keep separate low/high staging buffers.
package ept_pkg;
  localparam int NUM_THREADS = 6;
  localparam int PC_W        = 9;
  localparam int TIME_W      = 12;
  localparam logic [15:0] BASE_ADDR   = 16'hE000;
  localparam logic [15:0] THREAD_STEP = 16'h0010;
  // Register offsets within a thread's block
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STS    = 4'h1;
  localparam logic [3:0] OFS_R0L    = 4'h2;
  localparam logic [3:0] OFS_R0H    = 4'h3;
  localparam logic [3:0] OFS_R1L    = 4'h4;
  localparam logic [3:0] OFS_R1H    = 4'h5;
  localparam logic [3:0] OFS_PCL    = 4'h6;
  localparam logic [3:0] OFS_PCH    = 4'h7;
  localparam logic [3:0] OFS_TIMEL  = 4'h8;
  localparam logic [3:0] OFS_TIMEH  = 4'h9;
  // Field positions
  localparam int CTRL_RUN_BIT   = 7;
  localparam int CTRL_RESET_BIT = 6;
  localparam int STS_FORCE_A    = 5;
  localparam int STS_FORCE_B    = 4;
  localparam int STS_FLAG_A     = 1;
  localparam int STS_FLAG_B     = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {
    TS_STOPPED, TS_ACTIVE, TS_EVENT_WAIT, TS_TIMER_WAIT
  } ept_tstate_type;

  typedef enum logic [1:0] {
    PG_NONE, PG_A, PG_B, PG_C
  } ept_group_type;

  typedef enum logic [1:0] {
    SEL_R0, SEL_R1, SEL_PC, SEL_TIME
  } ept_wsel_type;

  // Host byte bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ept_hreq_type;

  // Core-side update of one thread
  typedef struct packed {
    logic                 state_we;
    ept_tstate_type       state;
    logic                 flag_a_we;
    logic                 flag_a;
    logic                 flag_b_we;
    logic                 flag_b;
    logic                 r0_we;
    logic [15:0]          r0;
    logic                 r1_we;
    logic [15:0]          r1;
    logic                 pc_we;
    logic [PC_W-1:0]      pc;
    logic                 time_we;
    logic [TIME_W-1:0]    time_v;
  } ept_core_upd_type;

  // Per-thread view handed to the core
  typedef struct packed {
    logic                 run_req;
    ept_group_type        group;
    ept_tstate_type       state;
    logic                 flag_a;
    logic                 flag_b;
    logic [15:0]          r0;
    logic [15:0]          r1;
    logic [PC_W-1:0]      pc;
    logic [TIME_W-1:0]    time_v;
  } ept_thread_view_type;
endpackage : ept_pkg

// ### logic/ept_regs.sv
module ept_regs (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // Host byte bus
  input  wire ept_pkg::ept_hreq_type         hreq,
  output logic [7:0]                         hrdata,
  output logic                               hsel,
  // Core port, one entry per thread
  input  wire ept_pkg::ept_core_upd_type     core_upd [ept_pkg::NUM_THREADS],
  output ept_pkg::ept_thread_view_type       view     [ept_pkg::NUM_THREADS],
  output logic [ept_pkg::NUM_THREADS-1:0]    presc_clr,
  // Core byte access staging (separate from the host's)
  input  wire logic                          cacc_wr,
  input  wire logic                          cacc_rd,
  input  wire logic [2:0]                    cacc_thr,
  input  wire logic [3:0]                    cacc_ofs,
  input  wire logic [7:0]                    cacc_wdata,
  output logic [7:0]                         cacc_rdata
);
  localparam int N = ept_pkg::NUM_THREADS;

  // ---------------------------------------------------------------
  // Per-thread storage
  // ---------------------------------------------------------------
  logic                          run_r   [N];
  ept_pkg::ept_group_type        grp_r   [N];
  ept_pkg::ept_tstate_type       tst_r   [N];
  logic                          fla_r   [N];
  logic                          flb_r   [N];
  logic [15:0]                   r0_r    [N];
  logic [15:0]                   r1_r    [N];
  logic [ept_pkg::PC_W-1:0]      pc_r    [N];
  logic [ept_pkg::TIME_W-1:0]    tim_r   [N];
  logic [N-1:0]                  presc_clr_r;
  // Host staging buffers, shared across threads like a byte-bus latch
  logic [7:0]                    hwbuf_r;
  logic [7:0]                    hrbuf_r;
  // Core staging buffers, kept apart so interleaving stays atomic
  logic [7:0]                    cwbuf_r;
  logic [7:0]                    crbuf_r;
  logic [7:0]                    hrdata_r;
  logic [7:0]                    cacc_rdata_r;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic [15:0] rel_addr = hreq.addr - ept_pkg::BASE_ADDR;
  wire logic [11:0] blk      = rel_addr[15:4];
  wire logic [3:0]  hofs     = rel_addr[3:0];
  wire logic        in_range = (hreq.addr >= ept_pkg::BASE_ADDR) &&
                               (blk >= 12'h001) && (blk <= 12'h006) &&
                               (hofs <= ept_pkg::OFS_TIMEH);
  wire logic [2:0]  hthr     = 3'(blk - 12'h001);
  wire logic        hwr      = hreq.wr && in_range;
  wire logic        hrd      = hreq.rd && in_range;
  wire logic        cthr_ok  = cacc_thr < 3'(N);

  assign hsel = in_range;

  // Read value of a full register at an offset, high byte as stored
  function automatic logic [15:0] word_of(input int t,
                                          input logic [3:0] ofs);
    logic [15:0] w;
    w = 16'h0000;
    case (ofs)
      ept_pkg::OFS_R0L, ept_pkg::OFS_R0H: w = r0_r[t];
      ept_pkg::OFS_R1L, ept_pkg::OFS_R1H: w = r1_r[t];
      ept_pkg::OFS_PCL, ept_pkg::OFS_PCH:
        w = {7'h00, pc_r[t]};
      ept_pkg::OFS_TIMEL, ept_pkg::OFS_TIMEH:
        w = {4'h0, tim_r[t]};
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : word_of

  // Byte read; high bytes come from the given latch
  function automatic logic [7:0] byte_rd(input int t,
                                         input logic [3:0] ofs,
                                         input logic [7:0] latch);
    logic [7:0] b;
    b = 8'h00;
    case (ofs)
      ept_pkg::OFS_CTRL:
        b = {run_r[t], 5'h00, grp_r[t]};
      ept_pkg::OFS_STS:
        b = {tst_r[t], 4'h0, fla_r[t], flb_r[t]};
      ept_pkg::OFS_R0L, ept_pkg::OFS_R1L,
      ept_pkg::OFS_PCL, ept_pkg::OFS_TIMEL:
        b = 8'(word_of(t, ofs));
      ept_pkg::OFS_R0H, ept_pkg::OFS_R1H,
      ept_pkg::OFS_PCH, ept_pkg::OFS_TIMEH:
        b = latch;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : byte_rd

  function automatic logic is_low(input logic [3:0] ofs);
    return (ofs == ept_pkg::OFS_R0L) || (ofs == ept_pkg::OFS_R1L) ||
           (ofs == ept_pkg::OFS_PCL) || (ofs == ept_pkg::OFS_TIMEL);
  endfunction : is_low

  // ---------------------------------------------------------------
  // Bus-side buffers and read data
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hwbuf_r      <= ept_pkg::RESET_BYTE;
      hrbuf_r      <= ept_pkg::RESET_BYTE;
      cwbuf_r      <= ept_pkg::RESET_BYTE;
      crbuf_r      <= ept_pkg::RESET_BYTE;
      hrdata_r     <= ept_pkg::RESET_BYTE;
      cacc_rdata_r <= ept_pkg::RESET_BYTE;
    end else begin
      if (hwr && is_low(hofs))
        hwbuf_r <= hreq.wdata;
      if (hrd && is_low(hofs))
        hrbuf_r <= 8'(word_of(int'(hthr), hofs) >> 8);
      if (cacc_wr && cthr_ok && is_low(cacc_ofs))
        cwbuf_r <= cacc_wdata;
      if (cacc_rd && cthr_ok && is_low(cacc_ofs))
        crbuf_r <= 8'(word_of(int'(cacc_thr), cacc_ofs) >> 8);
      if (hrd)
        hrdata_r <= byte_rd(int'(hthr), hofs, hrbuf_r);
      if (cacc_rd && cthr_ok)
        cacc_rdata_r <= byte_rd(int'(cacc_thr), cacc_ofs, crbuf_r);
    end
  end

  assign hrdata     = hrdata_r;
  assign cacc_rdata = cacc_rdata_r;
  assign presc_clr  = presc_clr_r;

  // ---------------------------------------------------------------
  // Thread registers
  // ---------------------------------------------------------------
  for (genvar t = 0; t < N; t++) begin : g_thr
    wire logic hit  = hwr && (hthr == 3'(t));
    wire logic chit = cacc_wr && (cacc_thr == 3'(t));
    wire logic [7:0] d = hreq.wdata;
    wire logic ctrl_w = hit && (hofs == ept_pkg::OFS_CTRL);
    wire logic sts_w  = hit && (hofs == ept_pkg::OFS_STS);
    wire logic treset = ctrl_w && d[ept_pkg::CTRL_RESET_BIT];
    wire logic clr_a  = sts_w && d[ept_pkg::STS_FLAG_A];
    wire logic clr_b  = sts_w && d[ept_pkg::STS_FLAG_B];
    wire logic set_a  = sts_w && d[ept_pkg::STS_FORCE_A];
    wire logic set_b  = sts_w && d[ept_pkg::STS_FORCE_B];
    // Committed words on a high-byte write, host then core
    wire logic [15:0] hword = {d, hwbuf_r};
    wire logic [15:0] cword = {cacc_wdata, cwbuf_r};
    wire logic h_r0  = hit  && (hofs == ept_pkg::OFS_R0H);
    wire logic h_r1  = hit  && (hofs == ept_pkg::OFS_R1H);
    wire logic h_pc  = hit  && (hofs == ept_pkg::OFS_PCH);
    wire logic h_tim = hit  && (hofs == ept_pkg::OFS_TIMEH);
    wire logic c_r0  = chit && (cacc_ofs == ept_pkg::OFS_R0H);
    wire logic c_r1  = chit && (cacc_ofs == ept_pkg::OFS_R1H);
    wire logic c_pc  = chit && (cacc_ofs == ept_pkg::OFS_PCH);
    wire logic c_tim = chit && (cacc_ofs == ept_pkg::OFS_TIMEH);

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        run_r[t]       <= 1'b0;
        grp_r[t]       <= ept_pkg::PG_NONE;
        tst_r[t]       <= ept_pkg::TS_STOPPED;
        fla_r[t]       <= 1'b0;
        flb_r[t]       <= 1'b0;
        r0_r[t]        <= 16'h0000;
        r1_r[t]        <= 16'h0000;
        pc_r[t]        <= '0;
        tim_r[t]       <= '0;
        presc_clr_r[t] <= 1'b0;
      end else begin
        presc_clr_r[t] <= treset;
        if (ctrl_w) begin
          run_r[t] <= d[ept_pkg::CTRL_RUN_BIT];
          grp_r[t] <= ept_pkg::ept_group_type'(d[1:0]);
        end
        if (treset)
          tst_r[t] <= ept_pkg::TS_STOPPED;
        else if (core_upd[t].state_we)
          tst_r[t] <= core_upd[t].state;
        // Clear beats force, force beats core
        if (clr_a)
          fla_r[t] <= 1'b0;
        else if (set_a)
          fla_r[t] <= 1'b1;
        else if (core_upd[t].flag_a_we)
          fla_r[t] <= core_upd[t].flag_a;
        if (clr_b)
          flb_r[t] <= 1'b0;
        else if (set_b)
          flb_r[t] <= 1'b1;
        else if (core_upd[t].flag_b_we)
          flb_r[t] <= core_upd[t].flag_b;
        // Host commit beats core update
        if (h_r0)
          r0_r[t] <= hword;
        else if (c_r0)
          r0_r[t] <= cword;
        else if (core_upd[t].r0_we)
          r0_r[t] <= core_upd[t].r0;
        if (h_r1)
          r1_r[t] <= hword;
        else if (c_r1)
          r1_r[t] <= cword;
        else if (core_upd[t].r1_we)
          r1_r[t] <= core_upd[t].r1;
        if (h_pc)
          pc_r[t] <= hword[ept_pkg::PC_W-1:0];
        else if (c_pc)
          pc_r[t] <= cword[ept_pkg::PC_W-1:0];
        else if (core_upd[t].pc_we)
          pc_r[t] <= core_upd[t].pc;
        if (h_tim)
          tim_r[t] <= hword[ept_pkg::TIME_W-1:0];
        else if (c_tim)
          tim_r[t] <= cword[ept_pkg::TIME_W-1:0];
        else if (core_upd[t].time_we)
          tim_r[t] <= core_upd[t].time_v;
      end
    end

    assign view[t] = '{run_req: run_r[t],
                       group:   grp_r[t],
                       state:   tst_r[t],
                       flag_a:  fla_r[t],
                       flag_b:  flb_r[t],
                       r0:      r0_r[t],
                       r1:      r1_r[t],
                       pc:      pc_r[t],
                       time_v:  tim_r[t]};
  end
endmodule : ept_regs

// ### testbench/ept_regs_monitor.sv
module ept_regs_monitor (
  // Clock and reset
  input wire logic                          sys_clk,
  input wire logic                          rst,
  // Watched ports
  input wire ept_pkg::ept_hreq_type         hreq,
  input wire logic [7:0]                    hrdata,
  input wire logic                          hsel,
  input wire ept_pkg::ept_core_upd_type     core_upd [ept_pkg::NUM_THREADS],
  input wire ept_pkg::ept_thread_view_type  view [ept_pkg::NUM_THREADS],
  input wire logic [ept_pkg::NUM_THREADS-1:0] presc_clr
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Decode, thread 0 is the watched thread
  // ----------------------------------------
  wire        wr0 = hreq.wr && hreq.addr[15:4] == 12'hE01;
  wire [3:0]  ofs = hreq.addr[3:0];
  wire [11:0] blk = hreq.addr[15:4];
  wire        hit = blk >= 12'hE01 && blk <= 12'hE06 && ofs <= 4'h9;
  sequence low_wr;
    wr0 && ofs == 4'h2;
  endsequence
  sequence high_wr;
    wr0 && ofs == 4'h3;
  endsequence
  sequence thr_rst;
    wr0 && ofs == 4'h0 && hreq.wdata[6] && !core_upd[0].state_we;
  endsequence
  a_word_commit: assert property (low_wr ##1 high_wr |=>
    view[0].r0 == {$past(hreq.wdata), $past(hreq.wdata, 2)})
    else $error("word does not hold the written byte pair");
  a_run_follow: assert property (wr0 && ofs == 4'h0 |=>
    view[0].run_req == $past(hreq.wdata[7]) &&
    view[0].group == $past(hreq.wdata[1:0]))
    else $error("run or group not taken from control write");
  a_reset_clear: assert property (thr_rst |=>
    presc_clr[0] && view[0].state == 2'h0)
    else $error("thread reset did not clear state");
  a_presc_cause: assert property (presc_clr[0] |->
    $past(wr0 && ofs == 4'h0 && hreq.wdata[6]))
    else $error("prescaler clear without reset write");
  a_flag_clear: assert property (wr0 && ofs == 4'h1 &&
    hreq.wdata[1] |=> !view[0].flag_a)
    else $error("flag not cleared by write of one");
  a_flag_force: assert property (wr0 && ofs == 4'h1 &&
    hreq.wdata[5] && !hreq.wdata[1] |=> view[0].flag_a)
    else $error("flag not forced");
  a_map_decode: assert property (hsel == hit)
    else $error("select does not match the map");
  a_rdata_hold: assert property (!(hreq.rd && hsel) |=>
    $stable(hrdata))
    else $error("read data moved without a read");
  a_high_reserved: assert property (hreq.rd && hsel &&
    ofs == 4'h7 |=> hrdata[7:1] == 7'h00)
    else $error("reserved counter bits not zero");
  a_sts_reserved: assert property (hreq.rd && hsel &&
    ofs == 4'h1 |=> hrdata[5:2] == 4'h0)
    else $error("status bits 5 to 2 not zero");
endmodule : ept_regs_monitor

bind ept_regs ept_regs_monitor i_ept_regs_monitor (.sys_clk(sys_clk),
  .rst(rst), .hreq(hreq), .hrdata(hrdata), .hsel(hsel),
  .core_upd(core_upd), .view(view), .presc_clr(presc_clr));

// ### testbench/ept_host_model.sv
module ept_host_model (
  // Bus
  input  wire logic            sys_clk,
  output ept_pkg::ept_hreq_type hreq,
  input  wire logic [7:0]      hrdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial hreq = '0;
  // One byte access; the bus idles a cycle before the next
  task automatic op(input logic w, input logic [15:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    #1 hreq = '{w, !w, a, d};
    @(posedge sys_clk);
    #1 hreq = '0;
    q = hrdata;
  endtask : op
  // Low byte, then high byte on the very next edge
  task automatic pair(input logic w, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk);
    #1 hreq = '{w, !w, a, d[7:0]};
    @(posedge sys_clk);
    #1 hreq = '{w, !w, a + 16'h0001, d[15:8]};
    q[7:0] = hrdata;
    @(posedge sys_clk);
    #1 hreq = '0;
    q[15:8] = hrdata;
  endtask : pair
endmodule : ept_host_model

// ### testbench/test_ept_regs.sv
module test_ept_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic                            sys_clk;
  logic                            rst;
  ept_pkg::ept_hreq_type           hreq;
  logic [7:0]                      hrdata;
  ept_pkg::ept_core_upd_type       core_upd [ept_pkg::NUM_THREADS];
  ept_pkg::ept_thread_view_type    view [ept_pkg::NUM_THREADS];
  logic [ept_pkg::NUM_THREADS-1:0] presc_clr;
  logic                            cacc_wr;
  logic                            cacc_rd;
  logic [3:0]                      cacc_ofs;
  logic [7:0]                      cacc_wdata;
  logic [7:0]                      cacc_rdata;
  logic [7:0]                      q;
  logic [15:0]                     q16;
  int                              errors = 0;
  int                              checked = 0;
  int                              cycles = 0;
  ept_host_model i_ept_host_model (.sys_clk(sys_clk), .hreq(hreq),
    .hrdata(hrdata));
  ept_regs i_ept_regs (.sys_clk(sys_clk), .rst(rst), .hreq(hreq),
    .hrdata(hrdata), .hsel(), .core_upd(core_upd), .view(view),
    .presc_clr(presc_clr), .cacc_wr(cacc_wr), .cacc_rd(cacc_rd),
    .cacc_thr(3'h5), .cacc_ofs(cacc_ofs), .cacc_wdata(cacc_wdata),
    .cacc_rdata(cacc_rdata));
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // A hang would otherwise run without end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic hw(input logic [15:0] a, input logic [7:0] d);
    i_ept_host_model.op(1'h1, a, d, q);
  endtask : hw
  task automatic hr(input logic [15:0] a);
    i_ept_host_model.op(1'h0, a, 8'h00, q);
  endtask : hr
  task automatic hp(input logic w, input logic [15:0] a,
                    input logic [15:0] d);
    i_ept_host_model.pair(w, a, d, q16);
  endtask : hp
  // Core byte access; read data is taken at the edge that answers
  task automatic ca(input logic w, input logic [3:0] o,
                    input logic [7:0] d);
    @(posedge sys_clk);
    #1 cacc_wr = w;
    cacc_rd = !w;
    cacc_ofs = o;
    cacc_wdata = d;
    @(posedge sys_clk);
    #1 cacc_wr = 1'h0;
    cacc_rd = 1'h0;
  endtask : ca
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int n = 0; n < 6; n++) begin
      for (int o = 0; o < 10; o++) begin
        hr(16'hE010 + 16'(16 * n + o));
        check(q, 16'h0000);
      end
    end
  endtask : t_reset
  task automatic t_ctrl;
    for (int n = 0; n < 6; n++) begin
      hw(16'hE010 + 16'(16 * n), 8'h80 | 8'(n % 4));
      check(view[n].run_req, 16'h0001);
      check(view[n].group, 16'(n % 4));
      hr(16'hE010 + 16'(16 * n));
      check(q, 16'h0080 | 16'(n % 4));
      hw(16'hE010 + 16'(16 * n), 8'h00);
      check(view[n].run_req, 16'h0000);
    end
  endtask : t_ctrl
  task automatic t_state;
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      #1 core_upd[0].state = ept_pkg::ept_tstate_type'(s);
      core_upd[0].state_we = 1'h1;
      @(posedge sys_clk);
      #1 core_upd[0].state_we = 1'h0;
      hr(16'hE011);
      check(q, 16'(s) << 6);
    end
    hw(16'hE010, 8'h40);
    check(presc_clr, 16'h0001);
    check(view[0].state, 16'h0000);
    hr(16'hE010);
    check(q, 16'h0000);
  endtask : t_state
  task automatic t_flags;
    hw(16'hE011, 8'h20);
    hr(16'hE011);
    check(q, 16'h0002);
    hw(16'hE011, 8'h10);
    hr(16'hE011);
    check(q, 16'h0003);
    hw(16'hE011, 8'h02);
    hr(16'hE011);
    check(q, 16'h0001);
    core_upd[0].flag_a_we = 1'h1;
    core_upd[0].flag_a = 1'h1;
    core_upd[0].flag_b_we = 1'h1;
    hw(16'hE011, 8'h10);
    check(view[0].flag_b, 16'h0001);
    hw(16'hE011, 8'h22);
    check(view[0].flag_a, 16'h0000);
    core_upd[0] = '0;
  endtask : t_flags
  task automatic t_words;
    logic [15:0] v [4];
    v = '{16'hA55A, 16'h3CC3, 16'h01A5, 16'h0B7E};
    for (int i = 0; i < 4; i++) begin
      hp(1'h1, 16'hE012 + 16'(2 * i), v[i]);
      hp(1'h0, 16'hE012 + 16'(2 * i), 16'h0000);
      check(q16, v[i]);
    end
    check(view[0].pc, 16'h01A5);
    check(view[0].time_v, 16'h0B7E);
    core_upd[0].r0 = 16'h1234;
    core_upd[0].r0_we = 1'h1;
    hp(1'h1, 16'hE012, 16'hC0DE);
    check(view[0].r0, 16'hC0DE);
    core_upd[0] = '0;
    // Core moves the timer between the two reads of the pair
    fork
      hp(1'h0, 16'hE018, 16'h0000);
      begin
        @(posedge sys_clk);
        #1 core_upd[0].time_v = 12'h4D2;
        core_upd[0].time_we = 1'h1;
        @(posedge sys_clk);
        #1 core_upd[0].time_we = 1'h0;
      end
    join
    check(q16, 16'h0B7E);
    hr(16'hE01A);
    check(q, 16'h000B);
    hp(1'h0, 16'hE018, 16'h0000);
    check(q16, 16'h04D2);
  endtask : t_words
  task automatic t_stage;
    ca(1'h1, 4'h2, 8'h11);
    hp(1'h1, 16'hE062, 16'hBEEF);
    check(view[5].r0, 16'hBEEF);
    ca(1'h1, 4'h3, 8'h22);
    check(view[5].r0, 16'h2211);
    hw(16'hE062, 8'h77);
    check(view[5].r0, 16'h2211);
    hw(16'hE063, 8'h66);
    check(view[5].r0, 16'h6677);
    // A host pair read between the core's two reads must not disturb
    // the core's own latch
    ca(1'h0, 4'h2, 8'h00);
    check(cacc_rdata, 16'h0077);
    hp(1'h0, 16'hE064, 16'h0000);
    check(q16, 16'h0000);
    ca(1'h0, 4'h3, 8'h00);
    check(cacc_rdata, 16'h0066);
  endtask : t_stage
  initial begin
    rst = 1'h1;
    cacc_wr = 1'h0;
    cacc_rd = 1'h0;
    cacc_ofs = 4'h0;
    cacc_wdata = 8'h00;
    foreach (core_upd[i]) core_upd[i] = '0;
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'h0;
    t_reset();
    t_ctrl();
    t_state();
    t_flags();
    t_words();
    t_stage();
    report_and_stop();
  end
endmodule : test_ept_regs
